// ---- verilog/zone_limit_consts.svh ----
// Register offsets, reset values and field positions for the zone limit bank
`ifndef ZONE_LIMIT_CONSTS_SVH
`define ZONE_LIMIT_CONSTS_SVH
`define ADDR_ZONE1_ABS      8'h6a
`define ADDR_ZONE2_ABS      8'h6b
`define ADDR_ZONE3_ABS      8'h6c
`define ADDR_ZONE12_HYST    8'h6d
`define ADDR_ZONE3_HYST     8'h6e
`define ADDR_TREE_TEST      8'h6f
`define ADDR_VENDOR_A       8'h79
`define ADDR_VENDOR_B       8'h7a
`define ADDR_VENDOR_C       8'h7b
`define RST_ABS_LIMIT       8'h64
`define RST_ZONE12_HYST     8'h44
`define RST_ZONE3_HYST      8'h40
`define RST_TREE_TEST       8'h00
`define RST_VENDOR          8'h00
`define ABS_DISABLE_CODE    8'h80
`define FULL_DUTY           8'hff
`define ZERO_DUTY           8'h00
`define ZONE3_HYST_MASK     8'hf0
`define TREE_TEST_MASK      8'h01
`define VENDOR_B_MASK       8'h7f
`define TREE_ENABLE_BIT     0
`define SYNC_STAGES         3
`endif

// ---- verilog/zone_limit_pkg.sv ----
// Types shared by the zone limit bank
package zone_limit_pkg;
	typedef logic signed [7:0] temp_t;
	typedef logic [3:0]        hyst_t;
	typedef logic [7:0]        duty_t;
	typedef logic [7:0]        byte_t;
	typedef enum logic [1:0] {
		FAN_OFF  = 2'b00,
		FAN_HOLD = 2'b01,
		FAN_RUN  = 2'b11
	} fan_state_t;
endpackage

// ---- verilog/zone_fan_if.sv ----
// Per-zone limit and state carrier between the bank and a zone tracker
`timescale 1ns/10ps
interface zone_fan_if;
	import zone_limit_pkg::*;
	temp_t      temp;
	temp_t      low_limit;
	hyst_t      hyst;
	logic       running;
	logic       holding;
	modport tracker (input temp, input low_limit, input hyst, output running, output holding);
	modport bank    (output temp, output low_limit, output hyst, input running, input holding);
endinterface

// ---- verilog/zone_hyst_tracker.sv ----
// Low-limit on/off tracking with hysteresis for one zone
`timescale 1ns/10ps
`include "zone_limit_consts.svh"
module zone_hyst_tracker (
	input  wire logic       clk_in,
	input  wire logic       srst_in,
	zone_fan_if.tracker     zf
);
	import zone_limit_pkg::*;

	fan_state_t state_q;
	logic signed [8:0] off_level;

	// Nine bits so the limit minus hysteresis cannot wrap
	assign off_level = 9'(zf.low_limit) - $signed({5'h00, zf.hyst});

	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			state_q <= FAN_OFF;
		end else begin
			unique case (state_q)
				FAN_OFF: if (zf.temp >= zf.low_limit) state_q <= FAN_RUN;
				FAN_RUN: if (zf.temp < zf.low_limit) state_q <= FAN_HOLD;
				FAN_HOLD: begin
					if (zf.temp >= zf.low_limit) begin
						state_q <= FAN_RUN;
					end else if (9'(zf.temp) < off_level) begin
						state_q <= FAN_OFF;
					end
				end
				default: state_q <= FAN_OFF;
			endcase
		end
	end

	assign zf.running = (state_q == FAN_RUN);
	assign zf.holding = (state_q == FAN_HOLD);

	chk_hold_until_off: assert property (@(posedge clk_in) disable iff (srst_in)
		(state_q == FAN_RUN && zf.temp < zf.low_limit) |=> (state_q == FAN_HOLD))
		else $error("fan did not drop to hold below low limit");
endmodule // zone_hyst_tracker

// ---- verilog/thermal_zone_limit_regs.sv ----
// Thermal zone limit registers, absolute override, hysteresis and pin tree test
`timescale 1ns/10ps
`include "zone_limit_consts.svh"

// Contract
// - Auto mode over absolute limit forces full duty
// - Absolute limit 80h disables zone override
// - Override hits manual fans, unassociated zones too
// - Three absolute limits, reset 64h
// - Limits are signed two's complement degrees
// - Hold minimum until below limit minus hysteresis
// - Hysteresis four bits, one degree each
// - Hysteresis nibble layout, resets 44h and 40h
// - Lock makes all registers read-only
// - Tree test enable bit 0, reset zero
// - Tree holds ident, speed inputs, drives 2,3
// - Three vendor test registers reset 00h
// - Fan turns on at low limit
// - Off-select picks zero or minimum below limit
module thermal_zone_limit_regs (
	input  wire logic                    clk_in,
	input  wire logic                    srst_in,
	input  wire logic                    reg_wr_in,
	input  wire logic [7:0]              reg_addr_in,
	input  wire zone_limit_pkg::byte_t   reg_wdata_in,
	output zone_limit_pkg::byte_t        reg_rdata_out,
	input  wire logic                    lock_in,
	input  wire zone_limit_pkg::temp_t   zone_temp_in [3],
	input  wire zone_limit_pkg::temp_t   zone_low_limit_in [3],
	input  wire logic [2:0]              fan_auto_in,
	input  wire logic [2:0]              fan_disabled_in,
	input  wire logic [2:0]              below_limit_select_in,
	input  wire logic [2:0]              fan_zone_sel_in [3],
	input  wire zone_limit_pkg::duty_t   fan_min_duty_in [3],
	input  wire zone_limit_pkg::duty_t   fan_demand_duty_in [3],
	input  wire zone_limit_pkg::byte_t   vendor_status_in,
	input  wire logic [4:0]              voltage_ident_in,
	input  wire logic [3:0]              fan_speed_in,
	output zone_limit_pkg::duty_t        fan_duty_out [3],
	output logic                         override_out,
	output logic                         tree_test_enable_out,
	output logic                         tree_test_out
);
	import zone_limit_pkg::*;

	// ----------------------------------------
	// Register state
	// ----------------------------------------
	temp_t  abs_limit_q [3];
	byte_t  zone12_hyst_q;
	byte_t  zone3_hyst_q;
	byte_t  tree_test_q;
	byte_t  vendor_a_q;
	byte_t  vendor_b_q;
	byte_t  vendor_c_q;
	logic   wr_ok;

	// Writes pass only while unlocked; lock is held until reset by its owner
	assign wr_ok = reg_wr_in && !lock_in;

	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			for (int i = 0; i < 3; i++) begin
				abs_limit_q[i] <= `RST_ABS_LIMIT;
			end
		end else if (wr_ok) begin
			// Signed bytes stored as written, compared signed below
			if (reg_addr_in == `ADDR_ZONE1_ABS) abs_limit_q[0] <= reg_wdata_in;
			if (reg_addr_in == `ADDR_ZONE2_ABS) abs_limit_q[1] <= reg_wdata_in;
			if (reg_addr_in == `ADDR_ZONE3_ABS) abs_limit_q[2] <= reg_wdata_in;
		end
	end

	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			zone12_hyst_q <= `RST_ZONE12_HYST;
			zone3_hyst_q  <= `RST_ZONE3_HYST;
		end else if (wr_ok) begin
			if (reg_addr_in == `ADDR_ZONE12_HYST) zone12_hyst_q <= reg_wdata_in;
			if (reg_addr_in == `ADDR_ZONE3_HYST) begin
				zone3_hyst_q <= reg_wdata_in & `ZONE3_HYST_MASK;
			end
		end
	end

	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			tree_test_q <= `RST_TREE_TEST;
		end else if (wr_ok && reg_addr_in == `ADDR_TREE_TEST) begin
			tree_test_q <= reg_wdata_in & `TREE_TEST_MASK;
		end
	end

	// Host writes to vendor A and C are accepted but steer nothing; vendor B ignores writes and follows vendor_status_in
	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			vendor_a_q <= `RST_VENDOR;
			vendor_b_q <= `RST_VENDOR;
			vendor_c_q <= `RST_VENDOR;
		end else begin
			vendor_b_q <= vendor_status_in & `VENDOR_B_MASK;
			if (wr_ok && reg_addr_in == `ADDR_VENDOR_A) vendor_a_q <= reg_wdata_in;
			if (wr_ok && reg_addr_in == `ADDR_VENDOR_C) vendor_c_q <= reg_wdata_in;
		end
	end

	// ----------------------------------------
	// Read port
	// ----------------------------------------
	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			reg_rdata_out <= 8'h00;
		end else begin
			unique case (reg_addr_in)
				`ADDR_ZONE1_ABS:   reg_rdata_out <= abs_limit_q[0];
				`ADDR_ZONE2_ABS:   reg_rdata_out <= abs_limit_q[1];
				`ADDR_ZONE3_ABS:   reg_rdata_out <= abs_limit_q[2];
				`ADDR_ZONE12_HYST: reg_rdata_out <= zone12_hyst_q;
				`ADDR_ZONE3_HYST:  reg_rdata_out <= zone3_hyst_q;
				`ADDR_TREE_TEST:   reg_rdata_out <= tree_test_q;
				`ADDR_VENDOR_A:    reg_rdata_out <= vendor_a_q;
				`ADDR_VENDOR_B:    reg_rdata_out <= vendor_b_q;
				`ADDR_VENDOR_C:    reg_rdata_out <= vendor_c_q;
				default:           reg_rdata_out <= 8'h00;
			endcase
		end
	end

	// ----------------------------------------
	// Zone trackers
	// ----------------------------------------
	hyst_t    zone_hyst [3];
	logic [2:0] zone_run;
	logic [2:0] zone_hold;

	assign zone_hyst[0] = zone12_hyst_q[7:4];
	assign zone_hyst[1] = zone12_hyst_q[3:0];
	assign zone_hyst[2] = zone3_hyst_q[7:4];

	zone_fan_if zf_if [3] ();

	genvar g;
	generate
		for (g = 0; g < 3; g++) begin : g_zone
			assign zf_if[g].temp      = zone_temp_in[g];
			assign zf_if[g].low_limit = zone_low_limit_in[g];
			assign zf_if[g].hyst      = zone_hyst[g];
			assign zone_run[g]        = zf_if[g].running;
			assign zone_hold[g]       = zf_if[g].holding;
			zone_hyst_tracker u_trk (
				.clk_in  (clk_in),
				.srst_in (srst_in),
				.zf      (zf_if[g])
			);
		end
	endgenerate

	// ----------------------------------------
	// Absolute override
	// ----------------------------------------
	logic [2:0] zone_over;
	logic       override_d;

	always_comb begin
		for (int i = 0; i < 3; i++) begin
			// 80h switches the zone out regardless of reading
			zone_over[i] = (abs_limit_q[i] != `ABS_DISABLE_CODE) &&
				(zone_temp_in[i] > abs_limit_q[i]);
		end
	end

	// Any zone counts, associated with a fan or not
	assign override_d = (|fan_auto_in) && (|zone_over);

	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			override_out <= 1'b0;
		end else begin
			override_out <= override_d;
		end
	end

	// ----------------------------------------
	// Fan duty selection
	// ----------------------------------------
	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			for (int f = 0; f < 3; f++) begin
				fan_duty_out[f] <= `ZERO_DUTY;
			end
		end else begin
			for (int f = 0; f < 3; f++) begin
				if (fan_disabled_in[f]) begin
					fan_duty_out[f] <= `ZERO_DUTY;
				end else if (override_d) begin
					fan_duty_out[f] <= `FULL_DUTY;
				end else if (!fan_auto_in[f]) begin
					fan_duty_out[f] <= fan_demand_duty_in[f];
				end else if (|(fan_zone_sel_in[f] & zone_run)) begin
					fan_duty_out[f] <= fan_demand_duty_in[f];
				end else if (|(fan_zone_sel_in[f] & zone_hold)) begin
					fan_duty_out[f] <= fan_min_duty_in[f];
				end else if (below_limit_select_in[f]) begin
					fan_duty_out[f] <= fan_min_duty_in[f];
				end else begin
					fan_duty_out[f] <= `ZERO_DUTY;
				end
			end
		end
	end

	// ----------------------------------------
	// Pin tree test
	// ----------------------------------------
	// Three-stage synchronisers; stage one feeds only stage two
	logic [8:0] pin_s1_q;
	logic [8:0] pin_s2_q;
	logic [8:0] pin_s3_q;
	logic [8:0] pin_stable_q;

	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			pin_s1_q <= 9'h000;
			pin_s2_q <= 9'h000;
			pin_s3_q <= 9'h000;
		end else begin
			pin_s1_q <= {voltage_ident_in, fan_speed_in};
			pin_s2_q <= pin_s1_q;
			pin_s3_q <= pin_s2_q;
		end
	end

	// A bit changes only once stages two and three agree
	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			pin_stable_q <= 9'h000;
		end else begin
			for (int b = 0; b < 9; b++) begin
				if (pin_s2_q[b] == pin_s3_q[b]) pin_stable_q[b] <= pin_s3_q[b];
			end
		end
	end

	assign tree_test_enable_out = tree_test_q[`TREE_ENABLE_BIT];

	// Bus lines stay out of the tree; drive 2 and 3 use the registered duty MSB
	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			tree_test_out <= 1'b0;
		end else if (tree_test_q[`TREE_ENABLE_BIT]) begin
			tree_test_out <= (^pin_stable_q) ^ fan_duty_out[1][7] ^ fan_duty_out[2][7];
		end else begin
			tree_test_out <= 1'b0;
		end
	end

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	chk_lock_blocks_write: assert property (@(posedge clk_in) disable iff (srst_in)
		(reg_wr_in && lock_in) |=> $stable(abs_limit_q[0]) && $stable(zone12_hyst_q))
		else $error("write landed while locked");
	chk_abs_disable: assert property (@(posedge clk_in) disable iff (srst_in)
		(abs_limit_q[0] == `ABS_DISABLE_CODE && abs_limit_q[1] == `ABS_DISABLE_CODE &&
		abs_limit_q[2] == `ABS_DISABLE_CODE)
		|=> !override_out)
		else $error("override with every zone disabled");
	chk_override_full: assert property (@(posedge clk_in) disable iff (srst_in)
		override_d && !fan_disabled_in[0] |=> fan_duty_out[0] == `FULL_DUTY)
		else $error("override did not drive full duty");
	chk_reserved_zero: assert property (@(posedge clk_in) disable iff (srst_in)
		zone3_hyst_q[3:0] == 4'h0 && tree_test_q[7:1] == 7'h00)
		else $error("reserved bits not zero");
	chk_tree_idle_low: assert property (@(posedge clk_in) disable iff (srst_in)
		!tree_test_q[0] |=> !tree_test_out)
		else $error("tree output active outside test");
	chk_vendor_b_msb: assert property (@(posedge clk_in) disable iff (srst_in)
		!vendor_b_q[7])
		else $error("vendor status bit 7 set");
endmodule // thermal_zone_limit_regs

// ---- test/host_model.sv ----
// Register host model driving the byte-wide write strobe port
`timescale 1ns/10ps
module host_model (
	input  wire logic       clk_in,
	input  wire logic [7:0] rdata_in,
	output logic            wr_out,
	output logic [7:0]      addr_out,
	output logic [7:0]      wdata_out,
	output logic            stb_out,
	output logic [7:0]      obs_out
);
	initial begin
		wr_out = 1'b0;
		addr_out = 8'h00;
		wdata_out = 8'h00;
		stb_out = 1'b0;
		obs_out = 8'h00;
	end
	// Write strobe one cycle; data inverted after so stale data never looks valid
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_in);
		addr_out <= a;
		wdata_out <= d;
		wr_out <= 1'b1;
		@(posedge clk_in);
		wr_out <= 1'b0;
		wdata_out <= ~d;
	endtask
	// Read data is registered, so take it two edges after the address
	task automatic rd(input logic [7:0] a);
		@(posedge clk_in);
		addr_out <= a;
		repeat (2) @(posedge clk_in);
		obs_out <= rdata_in;
		stb_out <= 1'b1;
		@(posedge clk_in);
		stb_out <= 1'b0;
	endtask
endmodule // host_model

// ---- test/testbench.sv ----
// Self-checking bench for the thermal zone limit register bank
`timescale 1ns/10ps
module testbench;
	import zone_limit_pkg::*;
	logic       clk_in = 1'b0;
	logic       srst_in = 1'b1;
	logic       lock_in = 1'b0;
	temp_t      zt [3];
	temp_t      zl [3];
	logic [2:0] f_auto, f_dis, f_off;
	logic [2:0] f_sel [3];
	duty_t      mind [3];
	duty_t      dem [3];
	byte_t      vstat, rdata, d;
	logic [4:0] vid;
	logic [3:0] spd;
	logic       wr, stb, ovr, ten, tout, prev;
	logic [7:0] addr, wdata, obs;
	duty_t      duty [3];
	byte_t      exp_q [$];
	byte_t      rnd = 8'h1d;
	int         n_errors = 0;
	int         total_checks = 0;
	int         cyc = 0;
	localparam byte_t RA [10] = '{8'h6a, 8'h6b, 8'h6c, 8'h6d, 8'h6e, 8'h6f, 8'h79, 8'h7a, 8'h7b, 8'h70};
	localparam byte_t RV [10] = '{8'h64, 8'h64, 8'h64, 8'h44, 8'h40, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
	localparam byte_t WM [10] = '{8'hff, 8'hff, 8'hff, 8'hff, 8'hf0, 8'h01, 8'hff, 8'h00, 8'hff, 8'h00};

	always #2 clk_in = ~clk_in;

	thermal_zone_limit_regs i_dut (.clk_in(clk_in), .srst_in(srst_in), .reg_wr_in(wr),
		.reg_addr_in(addr), .reg_wdata_in(wdata), .reg_rdata_out(rdata), .lock_in(lock_in),
		.zone_temp_in(zt), .zone_low_limit_in(zl), .fan_auto_in(f_auto),
		.fan_disabled_in(f_dis), .below_limit_select_in(f_off), .fan_zone_sel_in(f_sel),
		.fan_min_duty_in(mind), .fan_demand_duty_in(dem), .vendor_status_in(vstat),
		.voltage_ident_in(vid), .fan_speed_in(spd), .fan_duty_out(duty), .override_out(ovr),
		.tree_test_enable_out(ten), .tree_test_out(tout));

	host_model i_host (.clk_in(clk_in), .rdata_in(rdata), .wr_out(wr), .addr_out(addr),
		.wdata_out(wdata), .stb_out(stb), .obs_out(obs));

	// ----------------------------------------
	// Checking and helpers
	// ----------------------------------------
	function automatic byte_t lfsr(input byte_t s);
		return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
	endfunction
	task automatic check(input byte_t seen, input byte_t exp);
		total_checks++;
		if (seen !== exp) begin
			n_errors++;
			$display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic rd(input byte_t a, input byte_t e);
		exp_q.push_back(e);
		i_host.rd(a);
	endtask
	// Trailing step lets the edge's updates land before sampling
	task automatic cyc_wait(input int n);
		repeat (n) @(posedge clk_in);
		#1;
	endtask
	task automatic test_done();
		$display("checks %0d errors %0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	always @(posedge clk_in) begin
		cyc <= cyc + 1;
		if (stb) check(obs, exp_q.pop_front());
		if (cyc > 20000) begin
			n_errors++;
			test_done();
		end
	end

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		f_auto = 3'b000;
		f_dis = 3'b000;
		vid = 5'h00;
		spd = 4'h0;
		for (int i = 0; i < 3; i++) begin
			zt[i] = 8'h00;
			rnd = lfsr(rnd);
			zl[i] = rnd;
			mind[i] = rnd ^ 8'h5a;
			dem[i] = rnd ^ 8'h33;
			f_sel[i] = rnd[2:0];
		end
		f_off = rnd[5:3];
		vstat = lfsr(rnd);
		repeat (8) @(posedge clk_in);
		srst_in <= 1'b0;
		for (int i = 0; i < 10; i++) rd(RA[i], (RA[i] == 8'h7a) ? (vstat & 8'h7f) : RV[i]);
		$display("reset values done");
		for (int i = 0; i < 10; i++) begin
			rnd = lfsr(rnd);
			d = rnd;
			i_host.wr(RA[i], d);
			rd(RA[i], (d & WM[i]) | ((RA[i] == 8'h7a) ? (vstat & 8'h7f) : 8'h00));
		end
		$display("write readback done");
		for (int i = 0; i < 3; i++) i_host.wr(8'(8'h6a + i), 8'h64);
		i_host.wr(8'h6f, 8'h00);
		zt[0] <= 8'h65;
		f_auto <= 3'b001;
		f_dis <= 3'b100;
		cyc_wait(3);
		check({7'h0, ovr}, 8'h01);
		check(duty[0], 8'hff);
		check(duty[1], 8'hff);
		check(duty[2], 8'h00);
		zt[0] <= 8'h64;
		cyc_wait(3);
		check({7'h0, ovr}, 8'h00);
		zt[0] <= 8'h81;
		i_host.wr(8'h6a, 8'h80);
		cyc_wait(3);
		check({7'h0, ovr}, 8'h00);
		i_host.wr(8'h6b, 8'hce);
		zt[1] <= 8'h05;
		cyc_wait(3);
		check({7'h0, ovr}, 8'h01);
		zt[1] <= 8'hce;
		cyc_wait(3);
		check({7'h0, ovr}, 8'h00);
		zt[1] <= 8'h05;
		f_auto <= 3'b000;
		cyc_wait(3);
		check({7'h0, ovr}, 8'h00);
		$display("override done");
		f_dis <= 3'b000;
		i_host.wr(8'h6f, 8'hff);
		rd(8'h6f, 8'h01);
		cyc_wait(8);
		check({7'h0, ten}, 8'h01);
		// Fans 2 and 3 join the tree through their demand MSB in manual mode
		for (int i = 0; i < 11; i++) begin
			prev = tout;
			if (i < 5) vid[i] <= ~vid[i];
			else if (i < 9) spd[i - 5] <= ~spd[i - 5];
			else dem[i - 8] <= dem[i - 8] ^ 8'h80;
			cyc_wait(8);
			check({7'h0, tout}, {7'h0, ~prev});
		end
		$display("tree test done");
		lock_in <= 1'b1;
		i_host.wr(8'h6c, 8'h11);
		i_host.wr(8'h6f, 8'h00);
		rd(8'h6c, 8'h64);
		rd(8'h6f, 8'h01);
		srst_in <= 1'b1;
		cyc_wait(8);
		srst_in <= 1'b0;
		lock_in <= 1'b0;
		rd(8'h6a, 8'h64);
		$display("lock done");
		// Zone 1 hysteresis is 4 after reset, so the fan turns off below 1ch
		zl[0] <= 8'h20;
		f_sel[0] <= 3'b001;
		f_dis <= 3'b000;
		f_auto <= 3'b001;
		zt[0] <= 8'h20;
		cyc_wait(3);
		check(duty[0], dem[0]);
		zt[0] <= 8'h1e;
		cyc_wait(3);
		check(duty[0], mind[0]);
		zt[0] <= 8'h1c;
		cyc_wait(3);
		check(duty[0], mind[0]);
		zt[0] <= 8'h1b;
		cyc_wait(3);
		check(duty[0], f_off[0] ? mind[0] : 8'h00);
		$display("hysteresis done");
		for (int k = 0; k < 20 && exp_q.size() != 0; k++) @(posedge clk_in);
		if (exp_q.size() != 0) n_errors++;
		test_done();
	end
endmodule // testbench
